// >>> shared/tkf_consts.vh
`ifndef TKF_CONSTS_VH
`define TKF_CONSTS_VH
// Key command codes carried with each key event
`define TKF_K_CHAR 5'h00
`define TKF_K_RST 5'h01
`define TKF_K_STIN 5'h02
`define TKF_K_STTX 5'h03
`define TKF_K_CBC 5'h04
`define TKF_K_PRINT 5'h05
`define TKF_K_STORE 5'h06
`define TKF_K_FRAME 5'h07
`define TKF_K_READ 5'h08
`define TKF_K_LCOPY 5'h09
`define TKF_K_BREAK 5'h0A
`define TKF_K_ERASE 5'h0B
`define TKF_K_LF 5'h0C
`define TKF_K_CR 5'h0D
`define TKF_K_BS 5'h0E
`define TKF_K_LEFT 5'h0F
`define TKF_K_RIGHT 5'h10
`define TKF_K_UP 5'h11
`define TKF_K_DOWN 5'h12
`define TKF_K_HOME 5'h13
`define TKF_K_NEXT 5'h14
// Character codes
`define TKF_C_NUL 8'h00
`define TKF_C_BS 8'h08
`define TKF_C_RET 8'h1B
`define TKF_C_PERR 8'hB6
`define TKF_C_START 8'h12
`define TKF_C_STOP 8'h14
// Timing at 50 MHz
`define TKF_CLK_HZ 50000000
`define TKF_RPT_DELAY_MS 500
`define TKF_RPT_RATE_HZ 15
`define TKF_BRK_MS 225
`define TKF_RPT_DELAY_CYC (`TKF_CLK_HZ / 1000 * `TKF_RPT_DELAY_MS + 1)
`define TKF_RPT_PER_CYC (`TKF_CLK_HZ / `TKF_RPT_RATE_HZ)
`define TKF_BRK_CYC (`TKF_CLK_HZ / 1000 * `TKF_BRK_MS)
// Sequencer states
`define TKF_S_IDLE 3'h0
`define TKF_S_ERASE 3'h1
`define TKF_S_SCAN 3'h2
`define TKF_S_CLRLN 3'h3
`define TKF_S_READ 3'h4
`define TKF_S_STTX 3'h5
// Scan targets
`define TKF_T_PRN 2'h0
`define TKF_T_STO 2'h1
`define TKF_T_HOST 2'h2
`endif

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tkf_consts.vh"
module tb;
	localparam R = 4;
	localparam C = 8;
	logic core_clk = 0, arst_n = 0, key_valid = 0, key_held = 0, carrier_pin = 0, parity_en = 0;
	logic rx_valid = 0, rx_perr = 0, slow = 0;
	logic [4:0] key_cmd = 0;
	logic [7:0] key_char = 0, rx_char = 0, scr_rd_data, stor_in_char, line_char, prn_char, stor_out_char, scr_wr_data;
	logic line_ready, stor_in_valid, stor_eof, stor_ready, prn_ready, line_valid, line_space, stor_out_valid;
	logic stor_rec_req, prn_valid, scr_we, kbd_locked, char_by_char_mode, store_in_on, stor_tx_on, local_copy;
	logic parity_err, key_reject;
	logic [10:0] scr_addr, cursor;
	logic [15:0] rs = 16'd94;
	logic [7:0] lq[$], pq[$], sq[$], ch[3];
	logic [4:0] kt[12] = '{`TKF_K_LEFT, `TKF_K_RIGHT, `TKF_K_UP, `TKF_K_DOWN, `TKF_K_RIGHT, `TKF_K_NEXT, `TKF_K_LF,
		`TKF_K_CR, `TKF_K_LF, `TKF_K_NEXT, `TKF_K_LEFT, `TKF_K_HOME};
	int et[12] = '{R * C - 1, 0, (R - 1) * C, 0, 1, C, 2 * C, 2 * C, 3 * C, 0, R * C - 1, 0};
	logic [4:0] sc[5] = '{`TKF_K_PRINT, `TKF_K_FRAME, `TKF_K_STORE, `TKF_K_READ, `TKF_K_STTX};
	int failures = 0, samples_checked = 0, cyc = 0, i, j;
	tkf_ctrl #(.ROWS(R), .COLS(C), .AW(11), .RPT_DELAY(20), .RPT_PER(10), .BRK_LEN(50)) u_tkf_ctrl (.core_clk, .arst_n,
		.key_valid, .key_cmd, .key_char, .key_held, .carrier_pin, .parity_en, .rx_valid, .rx_char, .rx_perr,
		.line_ready, .stor_in_valid, .stor_in_char, .stor_eof, .stor_ready, .prn_ready, .scr_rd_data, .line_valid,
		.line_char, .line_space, .stor_out_valid, .stor_out_char, .stor_rec_req, .prn_valid, .prn_char, .scr_we,
		.scr_addr, .scr_wr_data, .cursor, .kbd_locked, .char_by_char_mode, .store_in_on, .stor_tx_on, .local_copy,
		.parity_err, .key_reject);
	tkf_far u_tkf_far (.core_clk, .arst_n, .slow, .scr_we, .scr_addr, .scr_wr_data, .stor_rec_req, .scr_rd_data,
		.prn_ready, .stor_ready, .line_ready, .stor_in_valid, .stor_in_char, .stor_eof);
	function logic [15:0] xs(input logic [15:0] v);
		v ^= v << 7;
		v ^= v >> 9;
		v ^= v << 8;
		return v;
	endfunction
	task check(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task test_done;
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One key event, then settle to the falling edge
	task key(input logic [4:0] k, input logic [7:0] v);
		@(posedge core_clk);
		key_cmd <= k;
		key_char <= v;
		key_valid <= 1'b1;
		@(posedge core_clk);
		key_valid <= 1'b0;
		@(negedge core_clk);
	endtask
	task rx;
		@(posedge core_clk);
		rx_char <= 8'h55;
		rx_perr <= 1'b1;
		rx_valid <= 1'b1;
		@(posedge core_clk);
		rx_valid <= 1'b0;
		repeat (3) @(negedge core_clk);
	endtask
	initial forever #10 core_clk = ~core_clk;
	// Hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			test_done;
		end
	end
	// Output watcher against the queued expectations
	always @(posedge core_clk) begin
		if (line_valid === 1'b1) check(line_char, (lq.size() > 0) ? lq.pop_front() : 16'hFFFF);
		if (prn_valid === 1'b1) check(prn_char, (pq.size() > 0) ? pq.pop_front() : 16'hFFFF);
		if (stor_out_valid === 1'b1) check(stor_out_char, (sq.size() > 0) ? sq.pop_front() : 16'hFFFF);
	end
	initial begin
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		@(negedge core_clk);
		check(char_by_char_mode, 0);
		for (i = 0; i < 12; i++) begin
			key(kt[i], 8'h00);
			repeat (8) @(negedge core_clk);
			check(cursor, et[i]);
		end
		check(u_tkf_far.mem[2 * C], `TKF_C_RET);
		check(u_tkf_far.mem[3 * C - 1], `TKF_C_NUL);
		// Held key: first repeat 20 cycles after the stroke, then every 10
		@(posedge core_clk);
		key_held <= 1'b1;
		key(`TKF_K_CHAR, 8'h41);
		repeat (34) @(posedge core_clk);
		key_held <= 1'b0;
		@(negedge core_clk);
		check(cursor, 3);
		key(`TKF_K_ERASE, 8'h00);
		repeat (40) @(negedge core_clk);
		check(cursor, 0);
		for (i = 0; i < 3; i++) begin
			rs = xs(rs);
			ch[i] = 8'h41 + rs[4:0];
			key(`TKF_K_CHAR, ch[i]);
		end
		check(cursor, 3);
		sq.push_back(`TKF_C_START);
		for (j = 0; j < 5; j++) begin
			for (i = 0; i < 3; i++) begin
				if (j == 0) pq.push_back(ch[i]);
				if (j == 1) lq.push_back(ch[i]);
				if (j == 2) sq.push_back(ch[i]);
				if (j == 4) lq.push_back(8'h44 - i[7:0]);
			end
			if (j == 2) sq.push_back(`TKF_C_STOP);
			rs = xs(rs);
			slow <= rs[0];
			key(sc[j], 8'h00);
			check(kbd_locked, 1);
			key(`TKF_K_CHAR, 8'h41);
			for (i = 0; i < 2000 && kbd_locked !== 1'b0; i++) @(negedge core_clk);
			check(kbd_locked, 0);
		end
		check(stor_tx_on, 0);
		key(`TKF_K_STIN, 8'h00);
		check({kbd_locked, store_in_on}, 3);
		key(`TKF_K_STIN, 8'h00);
		check(kbd_locked, 0);
		key(`TKF_K_CBC, 8'h00);
		check(char_by_char_mode, 0);
		@(posedge core_clk);
		carrier_pin <= 1'b1;
		repeat (4) @(negedge core_clk);
		key(`TKF_K_CBC, 8'h00);
		check(char_by_char_mode, 1);
		@(posedge core_clk);
		key_cmd <= `TKF_K_CHAR;
		key_valid <= 1'b1;
		for (i = 0; i < 3; i++) begin
			key_char <= ch[2 - i];
			lq.push_back(ch[2 - i]);
			@(posedge core_clk);
		end
		key_valid <= 1'b0;
		lq.push_back(`TKF_C_BS);
		key(`TKF_K_BS, 8'h00);
		key(`TKF_K_LCOPY, 8'h00);
		check(local_copy, 1);
		lq.push_back(8'h5A);
		key(`TKF_K_CHAR, 8'h5A);
		@(negedge core_clk);
		check(u_tkf_far.mem[cursor - 11'h001], 8'h5A);
		key(`TKF_K_BREAK, 8'h00);
		for (i = 0; i < 200 && line_space !== 1'b0; i++) @(negedge core_clk);
		check(line_space, 0);
		rx;
		check(parity_err, 0);
		check(u_tkf_far.mem[cursor - 11'h001], 8'h55);
		@(posedge core_clk);
		parity_en <= 1'b1;
		rx;
		check(parity_err, 1);
		check(u_tkf_far.mem[cursor - 11'h001], `TKF_C_PERR);
		key(`TKF_K_RST, 8'h00);
		check(parity_err, 0);
		repeat (10) @(negedge core_clk);
		check(lq.size() + pq.size() + sq.size(), 0);
		test_done;
	end
endmodule
`default_nettype wire

// >>> tb/tkf_far.sv
`timescale 1ns/1ps
`default_nettype none
`include "tkf_consts.vh"
module tkf_far (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic slow,
	input wire logic scr_we,
	input wire logic [10:0] scr_addr,
	input wire logic [7:0] scr_wr_data,
	input wire logic stor_rec_req,
	output logic [7:0] scr_rd_data,
	output logic prn_ready,
	output logic stor_ready,
	output logic line_ready,
	output logic stor_in_valid,
	output logic [7:0] stor_in_char,
	output logic stor_eof
);
	logic [7:0] mem [0:2047];
	logic [2:0] n;
	logic t;
	// Sinks stall every other cycle when slow
	assign prn_ready = !slow || t;
	assign stor_ready = !slow || t;
	assign line_ready = !slow || t;
	assign stor_eof = 1'b0;
	// Screen read data follows the address within the same cycle
	assign scr_rd_data = mem[scr_addr];
	// Screen memory and a record of three bytes closed by a stop code
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			n <= 3'h0;
			t <= 1'b0;
			stor_in_valid <= 1'b0;
			stor_in_char <= 8'h00;
		end else begin
			t <= ~t;
			if (scr_we)
				mem[scr_addr] <= scr_wr_data;
			stor_in_valid <= 1'b0;
			if (stor_rec_req) begin
				n <= 3'h4;
			end else if (n != 3'h0 && t) begin
				stor_in_valid <= 1'b1;
				stor_in_char <= (n == 3'h1) ? `TKF_C_STOP : 8'h40 + n;
				n <= n - 3'h1;
			end else begin
				stor_in_char <= ~stor_in_char;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/tkf_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "tkf_consts.vh"
module tkf_props #(parameter ROWS = 24, parameter COLS = 80, parameter AW = 11, parameter BRK_LEN = 50) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic key_valid,
	input wire logic [4:0] key_cmd,
	input wire logic carrier_pin,
	input wire logic parity_en,
	input wire logic line_valid,
	input wire logic [7:0] line_char,
	input wire logic line_space,
	input wire logic scr_we,
	input wire logic [AW-1:0] scr_addr,
	input wire logic [7:0] scr_wr_data,
	input wire logic [AW-1:0] cursor,
	input wire logic kbd_locked,
	input wire logic char_by_char_mode,
	input wire logic store_in_on,
	input wire logic parity_err,
	input wire logic key_reject
);
	logic [31:0] brk_cnt;
	logic [2:0] car_lo;
	wire tk = key_valid && !kbd_locked;
	// Break length and carrier-absent run counters
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			brk_cnt <= 32'h0;
			car_lo <= 3'h0;
		end else begin
			brk_cnt <= line_space ? brk_cnt + 32'h1 : 32'h0;
			car_lo <= carrier_pin ? 3'h0 : (car_lo == 3'h7 ? car_lo : car_lo + 3'h1);
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_break_len: assert property ($fell(line_space) |-> brk_cnt == BRK_LEN + 1) else $error("break length off");
	a_reject_lock: assert property (key_valid && kbd_locked && key_cmd != `TKF_K_RST && key_cmd != `TKF_K_STIN
		&& key_cmd != `TKF_K_STTX |=> key_reject) else $error("locked key not refused");
	a_cbc_carrier: assert property (tk && key_cmd == `TKF_K_CBC && car_lo > 3'h4 && !char_by_char_mode
		|=> !char_by_char_mode) else $error("char mode without carrier");
	a_parity_gate: assert property ($rose(parity_err) |-> $past(parity_en)) else $error("parity flag while disabled");
	a_parity_hold: assert property (parity_err && !(key_valid && key_cmd == `TKF_K_RST) |=> parity_err)
		else $error("parity flag dropped");
	a_erase_null: assert property (tk && key_cmd == `TKF_K_ERASE |=> ##1 scr_we && scr_wr_data == `TKF_C_NUL
		&& scr_addr == 0) else $error("erase not writing nulls");
	a_left_wrap: assert property (tk && key_cmd == `TKF_K_LEFT && cursor == 0 |=> cursor == ROWS * COLS - 1)
		else $error("left wrap wrong");
	a_up_wrap: assert property (tk && key_cmd == `TKF_K_UP && cursor < COLS
		|=> cursor == $past(cursor) + (ROWS - 1) * COLS) else $error("up wrap wrong");
	a_next_home: assert property (tk && key_cmd == `TKF_K_NEXT && cursor >= (ROWS - 1) * COLS |=> cursor == 0)
		else $error("next line wrap wrong");
	a_stin_lock: assert property (tk && key_cmd == `TKF_K_STIN && !store_in_on |=> store_in_on && kbd_locked)
		else $error("store input not locking");
	a_bs_send: assert property (tk && key_cmd == `TKF_K_BS && char_by_char_mode
		|=> line_valid && line_char == `TKF_C_BS) else $error("backspace not sent");
	c_break: cover property ($fell(line_space));
	c_parity: cover property ($rose(parity_err));
	c_reject: cover property (key_reject);
endmodule
bind tkf_ctrl tkf_props #(.ROWS(ROWS), .COLS(COLS), .AW(AW), .BRK_LEN(BRK_LEN)) u_tkf_props (.core_clk, .arst_n,
	.key_valid, .key_cmd, .carrier_pin, .parity_en, .line_valid, .line_char, .line_space, .scr_we, .scr_addr,
	.scr_wr_data, .cursor, .kbd_locked, .char_by_char_mode, .store_in_on, .parity_err, .key_reject);
`default_nettype wire

// >>> verilog/tkf_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "tkf_consts.vh"
module tkf_ctrl #(
	parameter ROWS = 24,
	parameter COLS = 80,
	parameter AW = 11,
	parameter RPT_DELAY = `TKF_RPT_DELAY_CYC,
	parameter RPT_PER = `TKF_RPT_PER_CYC,
	parameter BRK_LEN = `TKF_BRK_CYC
) (
	input wire core_clk,
	input wire arst_n,
	input wire key_valid,
	input wire [4:0] key_cmd,
	input wire [7:0] key_char,
	input wire key_held,
	input wire carrier_pin,
	input wire parity_en,
	input wire rx_valid,
	input wire [7:0] rx_char,
	input wire rx_perr,
	input wire line_ready,
	input wire stor_in_valid,
	input wire [7:0] stor_in_char,
	input wire stor_eof,
	input wire stor_ready,
	input wire prn_ready,
	input wire [7:0] scr_rd_data,
	output reg line_valid,
	output reg [7:0] line_char,
	output reg line_space,
	output reg stor_out_valid,
	output reg [7:0] stor_out_char,
	output reg stor_rec_req,
	output reg prn_valid,
	output reg [7:0] prn_char,
	output reg scr_we,
	output reg [AW-1:0] scr_addr,
	output reg [7:0] scr_wr_data,
	output reg [AW-1:0] cursor,
	output reg kbd_locked,
	output reg char_by_char_mode,
	output reg store_in_on,
	output reg stor_tx_on,
	output reg local_copy,
	output reg parity_err,
	output reg key_reject
);
	// Screen geometry cut to the address width on purpose
	localparam integer LAST_N = ROWS * COLS - 1;
	localparam integer COLS_N = COLS;
	localparam [AW-1:0] LAST = LAST_N[AW-1:0];
	localparam [AW-1:0] COLSW = COLS_N[AW-1:0];
	// Pin synchroniser for the carrier detect
	reg car_s1, car_s2;
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			car_s1 <= 1'b0;
			car_s2 <= 1'b0;
		end else begin
			car_s1 <= carrier_pin;
			car_s2 <= car_s1;
		end
	end
	// Line start of a position
	function [AW-1:0] tkf_lstart;
		input [AW-1:0] p;
		begin
			tkf_lstart = p - (p % COLSW);
		end
	endfunction
	reg [2:0] state;
	reg [1:0] target;
	reg [AW-1:0] ptr, end_ptr;
	reg scan_rd, scan_tag, scan_stop;
	reg cr_seen;
	reg [AW-1:0] cr_pos;
	reg [4:0] last_cmd;
	reg [7:0] last_char;
	reg [31:0] rpt_cnt;
	reg rpt_phase;
	reg [31:0] brk_cnt;
	wire busy = (state != `TKF_S_IDLE);
	wire [AW-1:0] col = cursor % COLSW;
	wire [AW-1:0] row_base = tkf_lstart(cursor);
	wire sink_rdy = (target == `TKF_T_PRN) ? prn_ready : (target == `TKF_T_STO) ? stor_ready : line_ready;
	// Key events arrive one per cycle in closure order and are consumed the same cycle
	wire allowed = (key_cmd == `TKF_K_RST) || (key_cmd == `TKF_K_STIN) || (key_cmd == `TKF_K_STTX);
	wire repeat_fire = key_held && rpt_phase && (rpt_cnt == 32'h00000000) && (last_cmd == `TKF_K_CHAR);
	wire ev = key_valid || repeat_fire;
	wire [4:0] ev_cmd = key_valid ? key_cmd : last_cmd;
	wire [7:0] ev_char = key_valid ? key_char : last_char;
	wire take = ev && (!kbd_locked || (key_valid && allowed)) && !busy | (ev && key_valid && allowed);
	// Auto-repeat timer
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rpt_cnt <= 32'h00000000;
			rpt_phase <= 1'b0;
			last_cmd <= `TKF_K_CHAR;
			last_char <= 8'h00;
		end else if (key_valid) begin
			last_cmd <= key_cmd;
			last_char <= key_char;
			rpt_phase <= 1'b1;
			rpt_cnt <= RPT_DELAY - 1;
		end else if (!key_held) begin
			rpt_phase <= 1'b0;
		end else if (rpt_cnt == 32'h00000000) begin
			rpt_cnt <= RPT_PER - 1;
		end else begin
			rpt_cnt <= rpt_cnt - 32'h00000001;
		end
	end
	// Main key, receive and transfer sequencer
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= `TKF_S_IDLE;
			target <= `TKF_T_PRN;
			ptr <= {AW{1'b0}};
			end_ptr <= {AW{1'b0}};
			scan_rd <= 1'b0;
			scan_tag <= 1'b0;
			scan_stop <= 1'b0;
			cr_seen <= 1'b0;
			cr_pos <= {AW{1'b0}};
			brk_cnt <= 32'h00000000;
			line_valid <= 1'b0;
			line_char <= 8'h00;
			line_space <= 1'b0;
			stor_out_valid <= 1'b0;
			stor_out_char <= 8'h00;
			stor_rec_req <= 1'b0;
			prn_valid <= 1'b0;
			prn_char <= 8'h00;
			scr_we <= 1'b0;
			scr_addr <= {AW{1'b0}};
			scr_wr_data <= 8'h00;
			cursor <= {AW{1'b0}};
			kbd_locked <= 1'b0;
			char_by_char_mode <= 1'b0;
			store_in_on <= 1'b0;
			stor_tx_on <= 1'b0;
			local_copy <= 1'b0;
			parity_err <= 1'b0;
			key_reject <= 1'b0;
		end else begin
			line_valid <= 1'b0;
			stor_out_valid <= 1'b0;
			prn_valid <= 1'b0;
			scr_we <= 1'b0;
			stor_rec_req <= 1'b0;
			key_reject <= ev && key_valid && !take;
			// Break timer on the line
			if (brk_cnt != 32'h00000000) begin
				brk_cnt <= brk_cnt - 32'h00000001;
			end else begin
				line_space <= 1'b0;
			end
			// Host data while not busy with a key transfer
			if (rx_valid && state == `TKF_S_IDLE) begin
				if (store_in_on) begin
					stor_out_valid <= 1'b1;
					stor_out_char <= rx_char;
				end
				if (char_by_char_mode) begin
					scr_we <= 1'b1;
					scr_addr <= cursor;
					scr_wr_data <= (rx_perr && parity_en) ? `TKF_C_PERR : rx_char;
					cursor <= (cursor == LAST) ? {AW{1'b0}} : cursor + 1'b1;
				end
				if (rx_perr && parity_en && (char_by_char_mode || store_in_on)) begin
					parity_err <= 1'b1;
				end
			end
			case (state)
			`TKF_S_IDLE: begin
				if (take) begin
					case (ev_cmd)
					`TKF_K_RST: begin
						state <= `TKF_S_IDLE;
						store_in_on <= 1'b0;
						stor_tx_on <= 1'b0;
						char_by_char_mode <= 1'b0;
						// A parity error landing with the reset still sets the flag
						parity_err <= rx_valid && rx_perr && parity_en && (char_by_char_mode || store_in_on);
						kbd_locked <= 1'b0;
					end
					`TKF_K_STIN: begin
						store_in_on <= !store_in_on;
						kbd_locked <= !store_in_on;
					end
					`TKF_K_STTX: begin
						if (!stor_tx_on) begin
							stor_tx_on <= 1'b1;
							kbd_locked <= 1'b1;
							stor_rec_req <= 1'b1;
							state <= `TKF_S_STTX;
						end else begin
							stor_tx_on <= 1'b0;
							kbd_locked <= store_in_on;
						end
					end
					`TKF_K_CBC: begin
						if (char_by_char_mode) begin
							char_by_char_mode <= 1'b0;
						end else if (car_s2) begin
							char_by_char_mode <= 1'b1;
						end
					end
					`TKF_K_LCOPY: local_copy <= !local_copy;
					`TKF_K_BREAK: begin
						line_space <= 1'b1;
						brk_cnt <= BRK_LEN;
					end
					`TKF_K_PRINT, `TKF_K_STORE, `TKF_K_FRAME: begin
						kbd_locked <= 1'b1;
						target <= (ev_cmd == `TKF_K_PRINT) ? `TKF_T_PRN :
							(ev_cmd == `TKF_K_STORE) ? `TKF_T_STO : `TKF_T_HOST;
						end_ptr <= (cursor == {AW{1'b0}}) ? LAST : cursor - 1'b1;
						ptr <= {AW{1'b0}};
						scan_rd <= 1'b0;
						scan_tag <= (ev_cmd == `TKF_K_STORE);
						scan_stop <= 1'b0;
						state <= `TKF_S_SCAN;
					end
					`TKF_K_READ: begin
						kbd_locked <= 1'b1;
						stor_rec_req <= 1'b1;
						state <= `TKF_S_READ;
					end
					`TKF_K_ERASE: begin
						ptr <= {AW{1'b0}};
						state <= `TKF_S_ERASE;
					end
					`TKF_K_LF: begin
						cursor <= (cursor + COLSW > LAST) ? col : cursor + COLSW;
						if (cr_seen) begin
							ptr <= cr_pos + 1'b1;
							end_ptr <= tkf_lstart(cr_pos) + COLSW - 1'b1;
							if (cr_pos % COLSW != COLSW - 1'b1) state <= `TKF_S_CLRLN;
						end
						cr_seen <= 1'b0;
					end
					`TKF_K_CR: begin
						scr_we <= 1'b1;
						scr_addr <= cursor;
						scr_wr_data <= `TKF_C_RET;
						cursor <= row_base;
						if (!cr_seen) cr_pos <= cursor;
						cr_seen <= 1'b1;
					end
					`TKF_K_BS: begin
						cursor <= (cursor == {AW{1'b0}}) ? LAST : cursor - 1'b1;
						line_valid <= 1'b1;
						line_char <= `TKF_C_BS;
					end
					`TKF_K_LEFT: cursor <= (cursor == {AW{1'b0}}) ? LAST : cursor - 1'b1;
					`TKF_K_RIGHT: cursor <= (cursor == LAST) ? {AW{1'b0}} : cursor + 1'b1;
					`TKF_K_UP: cursor <= (cursor < COLSW) ? LAST - COLSW + 1'b1 + col : cursor - COLSW;
					`TKF_K_DOWN: cursor <= (cursor + COLSW > LAST) ? col : cursor + COLSW;
					`TKF_K_HOME: cursor <= {AW{1'b0}};
					`TKF_K_NEXT: cursor <= (row_base + COLSW > LAST) ? {AW{1'b0}} : row_base + COLSW;
					default: begin
						if (char_by_char_mode) begin
							line_valid <= 1'b1;
							line_char <= ev_char;
						end
						if (!char_by_char_mode || local_copy) begin
							scr_we <= 1'b1;
							scr_addr <= cursor;
							scr_wr_data <= ev_char;
							cursor <= (cursor == LAST) ? {AW{1'b0}} : cursor + 1'b1;
						end
					end
					endcase
				end
			end
			`TKF_S_ERASE: begin
				scr_we <= 1'b1;
				scr_addr <= ptr;
				scr_wr_data <= `TKF_C_NUL;
				ptr <= ptr + 1'b1;
				if (ptr == LAST) begin
					cursor <= {AW{1'b0}};
					cr_seen <= 1'b0;
					state <= `TKF_S_IDLE;
				end
			end
			`TKF_S_CLRLN: begin
				scr_we <= 1'b1;
				scr_addr <= ptr;
				scr_wr_data <= `TKF_C_NUL;
				ptr <= ptr + 1'b1;
				if (ptr == end_ptr) state <= `TKF_S_IDLE;
			end
			`TKF_S_SCAN: begin
				// Issue a read, then pass the byte on when the sink is ready
				if (!scan_rd) begin
					scr_addr <= ptr;
					scan_rd <= 1'b1;
				end else if (sink_rdy) begin
					scan_rd <= 1'b0;
					if (target == `TKF_T_PRN) begin
						prn_valid <= 1'b1;
						prn_char <= scr_rd_data;
					end else if (target == `TKF_T_STO) begin
						stor_out_valid <= 1'b1;
						stor_out_char <= scan_tag ? `TKF_C_START : scan_stop ? `TKF_C_STOP : scr_rd_data;
					end else begin
						line_valid <= 1'b1;
						line_char <= scr_rd_data;
					end
					if (scan_tag) begin
						scan_tag <= 1'b0;
					end else if (scan_stop || (ptr == end_ptr && target != `TKF_T_STO)) begin
						kbd_locked <= store_in_on;
						state <= `TKF_S_IDLE;
					end else if (ptr == end_ptr) begin
						scan_stop <= 1'b1;
					end else begin
						ptr <= ptr + 1'b1;
					end
				end
			end
			`TKF_S_READ, `TKF_S_STTX: begin
				if (stor_in_valid && !(stor_in_char == `TKF_C_STOP)) begin
					scr_we <= 1'b1;
					scr_addr <= cursor;
					scr_wr_data <= stor_in_char;
					cursor <= (cursor == LAST) ? {AW{1'b0}} : cursor + 1'b1;
					if (state == `TKF_S_STTX) begin
						line_valid <= 1'b1;
						line_char <= stor_in_char;
					end
				end
				if (stor_eof || (stor_in_valid && stor_in_char == `TKF_C_STOP)) begin
					kbd_locked <= store_in_on;
					stor_tx_on <= 1'b0;
					state <= `TKF_S_IDLE;
				end
			end
			default: state <= `TKF_S_IDLE;
			endcase
			// Reset and the store input toggle still act while a transfer is running; store transmit only ends its own transfer
			if (take && key_valid && busy) begin
				if (key_cmd == `TKF_K_RST) begin
					state <= `TKF_S_IDLE;
					store_in_on <= 1'b0;
					stor_tx_on <= 1'b0;
					char_by_char_mode <= 1'b0;
					parity_err <= 1'b0;
					kbd_locked <= 1'b0;
				end else if (key_cmd == `TKF_K_STIN) begin
					store_in_on <= !store_in_on;
					if (!store_in_on) kbd_locked <= 1'b1;
				end else if (key_cmd == `TKF_K_STTX && state == `TKF_S_STTX) begin
					stor_tx_on <= 1'b0;
					kbd_locked <= store_in_on;
					state <= `TKF_S_IDLE;
				end
			end
		end
	end
endmodule
`default_nettype wire
